// File: inc/ppos_pkg.sv
// Constants and types shared by the port power, overcurrent and split logic
package ppos_pkg;

  localparam int unsigned NUM_PORTS = 7;
  localparam int unsigned NUM_SPLIT = 2;
  localparam int unsigned FIRST_SPLIT_IDX = 4;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned TICK_CYCLES =
    (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] LINK_TO_UNIT_MS = 16'h00C8;
  localparam logic [15:0] PULSE_BASE_MS = 16'h015E;
  localparam logic [15:0] PULSE_STEP_MS = 16'h000A;

  // Register offsets
  localparam logic [15:0] ADDR_LOCKOUT = 16'h30E1;
  localparam logic [15:0] ADDR_SINGLE_WIDTH = 16'h30EA;
  localparam logic [15:0] ADDR_DOUBLE_WINDOW = 16'h30EB;
  localparam logic [15:0] ADDR_SPLIT_PORTS = 16'h3C48;
  localparam logic [15:0] ADDR_SPLIT_GLOBAL = 16'h4141;
  localparam logic [15:0] ADDR_P5_PIN_SEL = 16'h416E;
  localparam logic [15:0] ADDR_P6_PIN_SEL = 16'h416F;
  localparam logic [15:0] ADDR_LINK_TIMEOUT = 16'h4171;
  localparam logic [15:0] ADDR_PULSE_LEN = 16'h4176;

  // Reset values
  localparam logic [7:0] RST_LOCKOUT = 8'h0A;
  localparam logic [3:0] RST_SINGLE_WIDTH = 4'h5;
  localparam logic [7:0] RST_DOUBLE_WINDOW = 8'h14;
  localparam logic [7:0] RST_SPLIT_PORTS = 8'h00;
  localparam logic RST_SPLIT_GLOBAL = 1'b0;
  localparam logic [7:0] RST_PIN_SEL = 8'h00;
  localparam logic [7:0] RST_LINK_TIMEOUT = 8'h05;
  localparam logic [7:0] RST_PULSE_LEN = 8'h05;

  // Field positions
  localparam int unsigned SPLIT_P5_BIT = 5;
  localparam int unsigned SPLIT_P6_BIT = 6;
  localparam int unsigned GLOBAL_EN_BIT = 0;

  // Pin select codes, port 5 then port 6
  localparam logic [7:0] SEL_P5_OPT_A = 8'h42;
  localparam logic [7:0] SEL_P5_OPT_B = 8'h05;
  localparam logic [7:0] SEL_P6_OPT_A = 8'h06;
  localparam logic [7:0] SEL_P6_OPT_B = 8'h04;

  // Link state codes judged stuck
  localparam logic [3:0] LINK_STUCK_LO = 4'h4;
  localparam logic [3:0] LINK_STUCK_HI = 4'h9;

  typedef struct packed {
    logic [3:0] width;
    logic [7:0] window;
    logic [7:0] lockout;
  } ppos_oc_cfg_t;

  typedef enum logic [0:0] {
    WD_WATCH = 1'b0,
    WD_PULSE = 1'b1
  } ppos_wd_state_t;

endpackage : ppos_pkg

// File: core/ppos_oc_filter.sv
// Overcurrent filter for one power/sense pin: lockout, single and double pulse
`timescale 1ns/1ps
module ppos_oc_filter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic powered_i,
  input wire logic sense_i,
  input wire ppos_pkg::ppos_oc_cfg_t cfg_i,
  output logic oc_o
);

  logic pwr_q;
  logic [7:0] lock_q;
  logic [3:0] low_ms_q;
  logic sense_q;
  logic first_q;
  logic [7:0] win_q;
  logic oc_q;
  logic power_up;
  logic armed;
  logic grp_start;
  logic single_hit;
  logic double_hit;

  assign power_up = powered_i & ~pwr_q;
  assign armed = powered_i & pwr_q & (lock_q == 8'h00);
  assign grp_start = armed & ~sense_i & sense_q;
  assign single_hit = armed & ~sense_i & (low_ms_q >= cfg_i.width);
  assign double_hit = grp_start & first_q;
  assign oc_o = oc_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= powered_i;
    end
  end

  // Pin state is ignored while the lockout runs down after power-on
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_q <= 8'h00;
    end else if (power_up) begin
      lock_q <= cfg_i.lockout;
    end else if (tick_i && lock_q != 8'h00) begin
      lock_q <= lock_q - 8'h01;
    end
  end

  // Continuous low time in whole ms, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_ms_q <= 4'h0;
    end else if (!armed || sense_i) begin
      low_ms_q <= 4'h0;
    end else if (tick_i && low_ms_q != 4'hF) begin
      low_ms_q <= low_ms_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sense_q <= 1'b1;
    end else if (power_up) begin
      sense_q <= 1'b1;
    end else if (armed) begin
      sense_q <= sense_i;
    end
  end

  // Rolling window opened by the first low group
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_q <= 1'b0;
      win_q <= 8'h00;
    end else if (power_up || !powered_i) begin
      first_q <= 1'b0;
      win_q <= 8'h00;
    end else if (grp_start && !first_q) begin
      first_q <= 1'b1;
      win_q <= cfg_i.window;
    end else if (first_q && tick_i) begin
      win_q <= win_q - 8'h01;
      if (win_q <= 8'h01) begin
        first_q <= 1'b0;
      end
    end
  end

  // Held until port power goes off; a low from a blown fuse counts the same
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_q <= 1'b0;
    end else if (single_hit || double_hit) begin
      oc_q <= 1'b1;
    end else if (!powered_i) begin
      oc_q <= 1'b0;
    end
  end

  AST_SINGLE_FIRES: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed && !sense_i && low_ms_q >= cfg_i.width) |=> oc_q)
    else $error("single pulse did not raise overcurrent");

  AST_DOUBLE_FIRES: assert property (@(posedge clk_i) disable iff (rst_i)
    (grp_start && first_q) |=> oc_q)
    else $error("double pulse did not raise overcurrent");

  AST_LOCKOUT_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(oc_q) |-> $past(lock_q) == 8'h00 && $past(pwr_q))
    else $error("overcurrent raised during lockout");

  AST_POWER_UP_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
    power_up |=> lock_q == $past(cfg_i.lockout) && !first_q)
    else $error("lockout not restarted on power-on");

  AST_LOW_IS_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed && !sense_i && cfg_i.width == 4'h0) |=> oc_q)
    else $error("low sense with zero width not flagged");

  COV_SINGLE: cover property (@(posedge clk_i) disable iff (rst_i)
    single_hit && !oc_q);
  COV_DOUBLE: cover property (@(posedge clk_i) disable iff (rst_i)
    double_hit && !single_hit);

endmodule : ppos_oc_filter

// File: core/ppos_top.sv
// Port power control, overcurrent filtering and USB 3 port splitting
`timescale 1ns/1ps
// What this block does
// - Powered: overcurrent when sense stays low for the single width.
// - Also overcurrent when two low groups fall in the double window.
// - In ganged mode a fault on the shared pin flags every port.
// - Single width is a 4-bit ms code, 0 to 15 ms, reset 5 ms.
// - Double window is an 8-bit ms count, reset 20 ms.
// - After power-on, ignore overcurrent until 8-bit ms lockout ends.
// - Lockout value resets to 10 ms.
// - Power off drives pin low; power on releases it with pull-up.
// - A fuse-opened low on sense counts as overcurrent, like a switch.
// - Splitting exists only on downstream ports 5 and 6.
// - Split: control pin keeps USB 2 half; own pin powers USB 3 half.
// - No overcurrent detection on the split USB 3 power pin.
// - Port 5 select: 0x42 picks option A pin, 0x05 option B.
// - Port 6 select: 0x06 picks option A pin, 0x04 option B.
// - Per-port enable: bit 5 port 5, bit 6 port 6, reset zero.
// - Splitting acts only with global enable bit 0 set, reset zero.
// - When split, watch the USB 3 link; toggle split pin on timeout.
// - Stuck means one link code in 0x4..0x9 held for the whole timeout.
// - The link timer clears and restarts on every timeout.
// - Timeout resets to 0x05 (one second); 0x00 disables it.
// - Split pin low time set by register, default 400 ms, 350 ms..2.9 s.
module ppos_top #(
  parameter int unsigned TICK_CYCLES = ppos_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic [15:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic gang_mode_i,
  input wire logic gang_power_en_i,
  input wire logic [6:0] port_power_en_i,
  input wire logic [6:0] port_power_sense_pin_i,
  output logic [6:0] port_power_sense_pin_o,
  output logic [6:0] port_power_sense_pin_oe_o,
  output logic [6:0] port_pullup_en_o,
  input wire logic shared_power_sense_pin_i,
  output logic shared_power_sense_pin_o,
  output logic shared_power_sense_pin_oe_o,
  output logic shared_pullup_en_o,
  input wire logic [7:0] ss_link_state_i,
  output logic [3:0] superspeed_half_power_pin_o,
  output logic [3:0] superspeed_half_power_pin_oe_o,
  output logic [6:0] oc_flags_o,
  output logic [1:0] split_active_o
);

  // Configuration registers
  logic [7:0] lockout_q;
  logic [3:0] single_width_q;
  logic [7:0] double_window_q;
  logic [7:0] split_ports_q;
  logic split_global_q;
  logic [7:0] p5_pin_sel_q;
  logic [7:0] p6_pin_sel_q;
  logic [7:0] link_timeout_q;
  logic [7:0] pulse_len_q;
  logic [7:0] rdata_q;

  // Tick divider
  logic [15:0] tick_cnt_q;
  logic tick_q;

  ppos_pkg::ppos_oc_cfg_t oc_cfg;
  logic [6:0] port_oc;
  logic gang_oc;
  logic [6:0] oc_flags_q;
  logic [6:0] pin_oe_q;
  logic [6:0] pin_o_q;
  logic [6:0] pullup_q;
  logic gang_oe_q;
  logic gang_o_q;
  logic gang_pullup_q;

  // Split support, index 0 is port 5, index 1 is port 6
  logic [1:0] opt_a;
  logic [1:0] opt_b;
  logic [1:0] split_act;
  logic [1:0] split_act_q;
  logic [1:0] wd_fire;
  logic [1:0] split_pwr;
  logic [3:0] ss_pin_q;
  logic [3:0] ss_oe_q;
  ppos_pkg::ppos_wd_state_t wd_state_q [2];
  logic [15:0] wd_cnt_q [2];
  logic [3:0] prev_link_q [2];
  logic [15:0] timeout_ms;
  logic [15:0] pulse_ms;

  assign oc_cfg.width = single_width_q;
  assign oc_cfg.window = double_window_q;
  assign oc_cfg.lockout = lockout_q;

  // Register writes; reserved bits never store
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lockout_q <= ppos_pkg::RST_LOCKOUT;
      single_width_q <= ppos_pkg::RST_SINGLE_WIDTH;
      double_window_q <= ppos_pkg::RST_DOUBLE_WINDOW;
      split_ports_q <= ppos_pkg::RST_SPLIT_PORTS;
      split_global_q <= ppos_pkg::RST_SPLIT_GLOBAL;
      p5_pin_sel_q <= ppos_pkg::RST_PIN_SEL;
      p6_pin_sel_q <= ppos_pkg::RST_PIN_SEL;
      link_timeout_q <= ppos_pkg::RST_LINK_TIMEOUT;
      pulse_len_q <= ppos_pkg::RST_PULSE_LEN;
    end else if (cfg_wr_i) begin
      case (cfg_addr_i)
        ppos_pkg::ADDR_LOCKOUT: lockout_q <= cfg_wdata_i;
        ppos_pkg::ADDR_SINGLE_WIDTH: single_width_q <= cfg_wdata_i[3:0];
        ppos_pkg::ADDR_DOUBLE_WINDOW: double_window_q <= cfg_wdata_i;
        ppos_pkg::ADDR_SPLIT_PORTS: begin
          split_ports_q <= 8'h00;
          split_ports_q[ppos_pkg::SPLIT_P5_BIT] <=
            cfg_wdata_i[ppos_pkg::SPLIT_P5_BIT];
          split_ports_q[ppos_pkg::SPLIT_P6_BIT] <=
            cfg_wdata_i[ppos_pkg::SPLIT_P6_BIT];
        end
        ppos_pkg::ADDR_SPLIT_GLOBAL: begin
          split_global_q <= cfg_wdata_i[ppos_pkg::GLOBAL_EN_BIT];
        end
        ppos_pkg::ADDR_P5_PIN_SEL: p5_pin_sel_q <= cfg_wdata_i;
        ppos_pkg::ADDR_P6_PIN_SEL: p6_pin_sel_q <= cfg_wdata_i;
        ppos_pkg::ADDR_LINK_TIMEOUT: link_timeout_q <= cfg_wdata_i;
        ppos_pkg::ADDR_PULSE_LEN: pulse_len_q <= cfg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // Read data follows the address one cycle later; unmapped reads zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      case (cfg_addr_i)
        ppos_pkg::ADDR_LOCKOUT: rdata_q <= lockout_q;
        ppos_pkg::ADDR_SINGLE_WIDTH: rdata_q <= {4'h0, single_width_q};
        ppos_pkg::ADDR_DOUBLE_WINDOW: rdata_q <= double_window_q;
        ppos_pkg::ADDR_SPLIT_PORTS: rdata_q <= split_ports_q;
        ppos_pkg::ADDR_SPLIT_GLOBAL: rdata_q <= {7'h00, split_global_q};
        ppos_pkg::ADDR_P5_PIN_SEL: rdata_q <= p5_pin_sel_q;
        ppos_pkg::ADDR_P6_PIN_SEL: rdata_q <= p6_pin_sel_q;
        ppos_pkg::ADDR_LINK_TIMEOUT: rdata_q <= link_timeout_q;
        ppos_pkg::ADDR_PULSE_LEN: rdata_q <= pulse_len_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign cfg_rdata_o = rdata_q;

  // One pulse per millisecond
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // One filter per port pin, plus one on the shared pin
  for (genvar k = 0; k < ppos_pkg::NUM_PORTS; k++) begin : g_port
    ppos_oc_filter u_filter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_q),
      .powered_i(port_power_en_i[k] & ~gang_mode_i),
      .sense_i(port_power_sense_pin_i[k]),
      .cfg_i(oc_cfg),
      .oc_o(port_oc[k])
    );
  end

  ppos_oc_filter u_gang_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_q),
    .powered_i(gang_power_en_i & gang_mode_i),
    .sense_i(shared_power_sense_pin_i),
    .cfg_i(oc_cfg),
    .oc_o(gang_oc)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_flags_q <= 7'h00;
    end else if (gang_mode_i) begin
      oc_flags_q <= {7{gang_oc}};
    end else begin
      oc_flags_q <= port_oc;
    end
  end

  assign oc_flags_o = oc_flags_q;

  // Open drain: drive low when off, release with pull-up when on.
  // Pull-up is off while driving low to save power.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_oe_q <= 7'h7F;
      pin_o_q <= 7'h00;
      pullup_q <= 7'h00;
      gang_oe_q <= 1'b0;
      gang_o_q <= 1'b0;
      gang_pullup_q <= 1'b0;
    end else begin
      pin_oe_q <= ~port_power_en_i;
      pin_o_q <= 7'h00;
      pullup_q <= port_power_en_i;
      gang_oe_q <= gang_mode_i & ~gang_power_en_i;
      gang_o_q <= 1'b0;
      gang_pullup_q <= gang_mode_i & gang_power_en_i;
    end
  end

  assign port_power_sense_pin_oe_o = pin_oe_q;
  assign port_power_sense_pin_o = pin_o_q;
  assign port_pullup_en_o = pullup_q;
  assign shared_power_sense_pin_oe_o = gang_oe_q;
  assign shared_power_sense_pin_o = gang_o_q;
  assign shared_pullup_en_o = gang_pullup_q;

  // Pin select decode; an unknown code leaves the port unsplit
  assign opt_a[0] = (p5_pin_sel_q == ppos_pkg::SEL_P5_OPT_A);
  assign opt_b[0] = (p5_pin_sel_q == ppos_pkg::SEL_P5_OPT_B);
  assign opt_a[1] = (p6_pin_sel_q == ppos_pkg::SEL_P6_OPT_A);
  assign opt_b[1] = (p6_pin_sel_q == ppos_pkg::SEL_P6_OPT_B);
  assign split_act[0] = split_global_q & (opt_a[0] | opt_b[0]) &
    split_ports_q[ppos_pkg::SPLIT_P5_BIT];
  assign split_act[1] = split_global_q & (opt_a[1] | opt_b[1]) &
    split_ports_q[ppos_pkg::SPLIT_P6_BIT];

  assign timeout_ms = 16'(link_timeout_q) * ppos_pkg::LINK_TO_UNIT_MS;
  assign pulse_ms = ppos_pkg::PULSE_BASE_MS +
    16'(pulse_len_q) * ppos_pkg::PULSE_STEP_MS;

  for (genvar j = 0; j < ppos_pkg::NUM_SPLIT; j++) begin : g_split
    logic [3:0] link;
    logic stuck;
    assign link = ss_link_state_i[4*j +: 4];
    assign stuck = (link >= ppos_pkg::LINK_STUCK_LO) &&
      (link <= ppos_pkg::LINK_STUCK_HI);
    assign wd_fire[j] = (wd_state_q[j] == ppos_pkg::WD_WATCH) && tick_q &&
      split_act[j] && (link_timeout_q != 8'h00) && stuck &&
      (link == prev_link_q[j]) && (wd_cnt_q[j] + 16'h0001 >= timeout_ms);

    // In WD_WATCH the count only grows while the code holds one stuck value; in WD_PULSE it counts the low time
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        wd_state_q[j] <= ppos_pkg::WD_WATCH;
        wd_cnt_q[j] <= 16'h0000;
        prev_link_q[j] <= 4'h0;
      end else begin
        prev_link_q[j] <= link;
        case (wd_state_q[j])
          ppos_pkg::WD_WATCH: begin
            if (!split_act[j] || link_timeout_q == 8'h00 || !stuck ||
                link != prev_link_q[j]) begin
              wd_cnt_q[j] <= 16'h0000;
            end else if (wd_fire[j]) begin
              wd_cnt_q[j] <= 16'h0000;
              wd_state_q[j] <= ppos_pkg::WD_PULSE;
            end else if (tick_q) begin
              wd_cnt_q[j] <= wd_cnt_q[j] + 16'h0001;
            end
          end
          ppos_pkg::WD_PULSE: begin
            // Dropping the split abandons the pulse so no stale state lingers
            if (!split_act[j] ||
                (tick_q && wd_cnt_q[j] + 16'h0001 >= pulse_ms)) begin
              wd_cnt_q[j] <= 16'h0000;
              wd_state_q[j] <= ppos_pkg::WD_WATCH;
            end else if (tick_q) begin
              wd_cnt_q[j] <= wd_cnt_q[j] + 16'h0001;
            end
          end
          default: begin
            wd_state_q[j] <= ppos_pkg::WD_WATCH;
            wd_cnt_q[j] <= 16'h0000;
          end
        endcase
      end
    end

    // USB 3 half follows port power, dropped during a link reset pulse
    assign split_pwr[j] = split_act[j] &
      port_power_en_i[ppos_pkg::FIRST_SPLIT_IDX + j] &
      (wd_state_q[j] == ppos_pkg::WD_WATCH);
  end

  // Split pins are push-pull outputs with no sense path
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ss_pin_q <= 4'h0;
      ss_oe_q <= 4'h0;
      split_act_q <= 2'b00;
    end else begin
      ss_oe_q <= {opt_b[1], opt_a[1], opt_b[0], opt_a[0]} &
        {{2{split_act[1]}}, {2{split_act[0]}}};
      ss_pin_q <= {{2{split_pwr[1]}}, {2{split_pwr[0]}}};
      split_act_q <= split_act;
    end
  end

  assign superspeed_half_power_pin_o = ss_pin_q;
  assign superspeed_half_power_pin_oe_o = ss_oe_q;
  assign split_active_o = split_act_q;

  AST_PIN_OFF_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> ((~$past(port_power_en_i) & ~port_power_sense_pin_oe_o) == 7'h00)
      && (port_power_sense_pin_o == 7'h00))
    else $error("unpowered port pin not driven low");

  AST_GANG_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
    (gang_mode_i && gang_oc) |=> oc_flags_o == 7'h7F)
    else $error("ganged fault not flagged on all ports");

  AST_GLOBAL_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !split_global_q |=> split_active_o == 2'b00 &&
      superspeed_half_power_pin_oe_o == 4'h0)
    else $error("split active without global enable");

  AST_TIMEOUT_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    wd_fire[0] && split_act[0] |=> wd_cnt_q[0] == 16'h0000 ##1
      superspeed_half_power_pin_o[1:0] == 2'b00)
    else $error("link timeout did not drop split pin");

  AST_NO_TIMEOUT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    link_timeout_q == 8'h00 |-> wd_fire == 2'b00)
    else $error("link timeout fired while disabled");

  COV_SPLIT_P5: cover property (@(posedge clk_i) disable iff (rst_i)
    split_act_q[0]);
  COV_WD_FIRE: cover property (@(posedge clk_i) disable iff (rst_i)
    wd_fire[1]);
  COV_GANG: cover property (@(posedge clk_i) disable iff (rst_i)
    gang_mode_i && gang_oc);

endmodule : ppos_top

// File: dv/ppos_power_switch_model.sv
// Far-side model: power switches or poly fuses on the sense pins
`timescale 1ns/1ps
module ppos_power_switch_model (
  input wire logic [6:0] oe_i,
  input wire logic [6:0] pullup_i,
  input wire logic [6:0] fault_i,
  input wire logic gang_oe_i,
  input wire logic gang_pullup_i,
  input wire logic gang_fault_i,
  output logic [6:0] sense_o,
  output logic gang_sense_o
);
  // A fault is a tripped switch or an opened fuse: both read low
  // Fuse wiring has no power-good delay to report
  // Released pin without pull-up sits at the board's weak pull-down
  assign sense_o = ~(oe_i | fault_i) & pullup_i;
  assign gang_sense_o = ~(gang_oe_i | gang_fault_i) & gang_pullup_i;
endmodule : ppos_power_switch_model

// File: dv/test_port_power_overcurrent_split.sv
// Self-checking bench for port power, overcurrent and split logic
`timescale 1ns/1ps
module test_port_power_overcurrent_split;
  localparam int TK = 10;
  logic clk_i = 1'b0, rst_i = 1'b1, cfg_wr_i = 1'b0;
  logic gang_mode_i = 1'b0, gang_power_en_i = 1'b0, gfault = 1'b0;
  logic [15:0] cfg_addr_i = 16'h0000;
  logic [7:0] cfg_wdata_i = 8'h00, ss_link_state_i = 8'h00, cfg_rdata_o;
  logic [6:0] port_power_en_i = 7'h00, fault = 7'h00, sense, pin_o;
  logic [6:0] pin_oe, pull, oc_flags_o;
  logic gsense, g_o, g_oe, g_pull;
  logic [3:0] ss_o, ss_oe;
  logic [1:0] split_active_o;
  int mismatches = 0;
  int n_tests = 0;

  ppos_top #(.TICK_CYCLES(TK)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .gang_mode_i(gang_mode_i),
    .gang_power_en_i(gang_power_en_i), .port_power_en_i(port_power_en_i),
    .port_power_sense_pin_i(sense), .port_power_sense_pin_o(pin_o),
    .port_power_sense_pin_oe_o(pin_oe), .port_pullup_en_o(pull),
    .shared_power_sense_pin_i(gsense), .shared_power_sense_pin_o(g_o),
    .shared_power_sense_pin_oe_o(g_oe), .shared_pullup_en_o(g_pull),
    .ss_link_state_i(ss_link_state_i),
    .superspeed_half_power_pin_o(ss_o),
    .superspeed_half_power_pin_oe_o(ss_oe),
    .oc_flags_o(oc_flags_o), .split_active_o(split_active_o));

  ppos_power_switch_model far_u (
    .oe_i(pin_oe), .pullup_i(pull), .fault_i(fault), .gang_oe_i(g_oe),
    .gang_pullup_i(g_pull), .gang_fault_i(gfault), .sense_o(sense),
    .gang_sense_o(gsense));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_wr_i = 1'b1;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    cfg_addr_i = a;
    @(negedge clk_i);
    chk(cfg_rdata_o, exp);
  endtask : rd

  task automatic ms(input int n);
    repeat (n * TK) @(negedge clk_i);
  endtask : ms

  // Window and lockout are never written as zero here
  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    chk({1'b0, pin_oe}, 8'h7F);
    chk({1'b0, pin_o}, 8'h00);
    rd(16'h30E1, 8'h0A);
    rd(16'h30EA, 8'h05);
    rd(16'h30EB, 8'h14);
    rd(16'h3C48, 8'h00);
    rd(16'h4141, 8'h00);
    rd(16'h4171, 8'h05);
    wr(16'h30EA, 8'hF5);
    rd(16'h30EA, 8'h05);
    wr(16'h3C48, 8'hFF);
    rd(16'h3C48, 8'h60);
    wr(16'h4141, 8'hFE);
    rd(16'h4141, 8'h00);
    rd(16'h1234, 8'h00);
    wr(16'h3C48, 8'h00);
    // Fault present from power-on: masked by lockout, then single width
    fault[0] = 1'b1;
    port_power_en_i[0] = 1'b1;
    ms(1);
    chk({6'h00, pin_oe[0], pull[0]}, 8'h01);
    ms(7);
    chk({1'b0, oc_flags_o}, 8'h00);
    ms(9);
    chk({1'b0, oc_flags_o}, 8'h01);
    fault[0] = 1'b0;
    port_power_en_i[0] = 1'b0;
    ms(1);
    chk({1'b0, oc_flags_o}, 8'h00);
    // Two short lows, each far below the single width
    port_power_en_i[0] = 1'b1;
    ms(11);
    fault[0] = 1'b1;
    ms(1);
    fault[0] = 1'b0;
    ms(2);
    chk({1'b0, oc_flags_o}, 8'h00);
    fault[0] = 1'b1;
    ms(1);
    fault[0] = 1'b0;
    ms(1);
    chk({1'b0, oc_flags_o}, 8'h01);
    port_power_en_i[0] = 1'b0;
    gang_mode_i = 1'b1;
    gang_power_en_i = 1'b1;
    gfault = 1'b1;
    ms(17);
    chk({1'b0, oc_flags_o}, 8'h7F);
    chk({5'h00, g_o, g_oe, g_pull}, 8'h01);
    gfault = 1'b0;
    gang_power_en_i = 1'b0;
    gang_mode_i = 1'b0;
    // Port 5 split on option A, link held stuck, shortest timings
    // Both pins of a split pair carry the level; only the selected one drives
    wr(16'h416E, 8'h42);
    wr(16'h3C48, 8'h20);
    wr(16'h4141, 8'h01);
    wr(16'h4171, 8'h01);
    wr(16'h4176, 8'h00);
    port_power_en_i[4] = 1'b1;
    ss_link_state_i = 8'h04;
    ms(1);
    chk({ss_oe, ss_o}, 8'h13);
    chk({6'h00, split_active_o}, 8'h01);
    ms(196);
    chk({4'h0, ss_o}, 8'h03);
    ms(6);
    chk({4'h0, ss_o}, 8'h00);
    ms(345);
    chk({4'h0, ss_o}, 8'h00);
    ms(10);
    chk({4'h0, ss_o}, 8'h03);
    ms(190);
    chk({4'h0, ss_o}, 8'h03);
    ms(15);
    chk({4'h0, ss_o}, 8'h00);
    ss_link_state_i = 8'h00;
    wr(16'h4141, 8'h00);
    ms(1);
    chk({ss_oe, 2'b00, split_active_o}, 8'h00);
    wr(16'h416F, 8'h04);
    wr(16'h3C48, 8'h40);
    wr(16'h4141, 8'h01);
    port_power_en_i[5] = 1'b1;
    ms(1);
    chk({ss_oe, ss_o}, 8'h8C);
    wr(16'h416E, 8'h05);
    wr(16'h416F, 8'h06);
    wr(16'h3C48, 8'h60);
    ms(1);
    chk({ss_oe, ss_o}, 8'h6F);
    // Timeout code zero: a stuck link must never pulse the pin
    wr(16'h4171, 8'h00);
    ss_link_state_i = 8'h04;
    ms(205);
    chk({4'h0, ss_o}, 8'h0F);
    tally_and_finish();
  end

  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
endmodule : test_port_power_overcurrent_split
